//--- core/uvr_delay_timer.sv
// binary-weighted delay timer counted in delay units
`timescale 1ns/1ps
`default_nettype none
module uvr_delay_timer (
    // clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   rst_i,
    // control
    uvr_dly_if.timer    dly
);
    logic        run_q;
    logic [15:0] unit_cnt_q;
    logic [7:0]  units_q;
    logic        done_q;
    logic [15:0] unit_len;
    logic        unit_end;

    // a zero unit length runs as one cycle
    assign unit_len = (dly.unit == 16'h0000) ? 16'h0001 : dly.unit;
    assign unit_end = (unit_cnt_q == 16'h0001);
    assign dly.done = done_q;

    // unit and unit-count counters
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_q      <= 1'b0;
            unit_cnt_q <= 16'h0000;
            units_q    <= 8'h00;
            done_q     <= 1'b0;
        end else if (dly.start) begin
            run_q      <= 1'b1;
            unit_cnt_q <= unit_len;
            units_q    <= 8'(8'h01 << dly.code);
            done_q     <= 1'b0;
        end else if (dly.abort || !run_q) begin
            run_q      <= 1'b0;
            done_q     <= 1'b0;
        end else if (unit_end) begin
            unit_cnt_q <= unit_len;
            units_q    <= units_q - 8'h01;
            run_q      <= (units_q != 8'h01);
            done_q     <= (units_q == 8'h01);
        end else begin
            unit_cnt_q <= unit_cnt_q - 16'h0001;
            done_q     <= 1'b0;
        end
    end
endmodule : uvr_delay_timer
`default_nettype wire

//--- core/uvr_supervisor.sv
// output undervoltage supervisor: thresholds, fault response and retries
`timescale 1ns/1ps
`default_nettype none
module uvr_supervisor #(
    // width of the two thresholds and of the measurement
    parameter int LIMIT_W = 16
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // register port, same clock domain
    input  wire logic [7:0]  reg_cmd_i,
    input  wire logic        reg_wr_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    // measurement and delay unit, same clock domain
    input  wire logic [LIMIT_W-1:0] vout_i,
    input  wire logic [15:0] delay_unit_cycles_i,
    // clearing and on/off commands
    input  wire logic        fault_bit_clr_i,
    input  wire logic        clear_faults_i,
    input  wire logic        operation_on_i,
    input  wire logic        ctrl_pin_i,
    input  wire logic        other_fault_off_i,
    // status and power stage
    output logic             output_en_o,
    output logic             uv_warning_o,
    output logic             uv_fault_o
);
    // carrier to the delay timer
    uvr_dly_if dly ();

    // readback is 16 bits wide, so wider thresholds cannot be served
    if (LIMIT_W < 1 || LIMIT_W > 16) begin : g_bad_limit_w
        $error("threshold width must lie between 1 and 16");
    end

    logic [LIMIT_W-1:0]    warn_lim_q;
    logic [LIMIT_W-1:0]    fault_lim_q;
    logic [7:0]            action_q;
    logic                  pin_meta_q;
    logic                  pin_q;
    logic                  warn_q;
    logic                  flag_q;
    logic [2:0]            tries_q;
    logic [15:0]           rdata_q;
    uvr_pkg::uvr_state_e   state_q;
    uvr_pkg::uvr_state_e   state_d;

    // fields of the action register
    wire [1:0] resp      = action_q[uvr_pkg::ACT_RESP_LSB +: 2];
    wire [2:0] retries   = action_q[uvr_pkg::ACT_RETRY_LSB +: 3];
    wire [2:0] dly_code  = action_q[uvr_pkg::ACT_DELAY_LSB +: 3];

    // register select, shared by the write and the read path
    wire       sel_warn  = (reg_cmd_i == uvr_pkg::OFS_WARN_LIMIT);
    wire       sel_fault = (reg_cmd_i == uvr_pkg::OFS_FAULT_LIMIT);
    wire       sel_act   = (reg_cmd_i == uvr_pkg::OFS_ACTION);

    // on command and threshold comparisons
    wire       cmd_on    = operation_on_i & pin_q;
    wire       uv_fault  = (vout_i < fault_lim_q);
    wire       uv_warn   = (vout_i < warn_lim_q);

    // retry bookkeeping and response events
    wire       clear_req = fault_bit_clr_i | clear_faults_i;
    wire       forever_r = (retries == uvr_pkg::RETRY_FOREVER);
    wire       tries_left = forever_r || (tries_q < retries);
    wire       in_run    = (state_q == uvr_pkg::ST_RUN);
    wire       resp_enter = in_run && uv_fault;
    wire       go_retry  = (resp_enter && resp == uvr_pkg::RESP_SHUTDOWN)
                         || (state_q == uvr_pkg::ST_DELAY && dly.done && uv_fault);
    wire       try_fail  = (state_q == uvr_pkg::ST_TRY) && dly.done && uv_fault;

    // control pin comes from outside: two-stage synchroniser
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= 1'b0;
            pin_q      <= 1'b0;
        end else begin
            pin_meta_q <= ctrl_pin_i;
            pin_q      <= pin_meta_q;
        end
    end

    // threshold and action registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_lim_q  <= LIMIT_W'(uvr_pkg::RST_WARN_LIMIT);
            fault_lim_q <= LIMIT_W'(uvr_pkg::RST_FAULT_LIMIT);
            action_q    <= uvr_pkg::RST_ACTION;
        end else if (reg_wr_i) begin
            if (sel_warn)
                warn_lim_q <= reg_wdata_i[LIMIT_W-1:0];
            if (sel_fault)
                fault_lim_q <= reg_wdata_i[LIMIT_W-1:0];
            if (sel_act)
                action_q <= reg_wdata_i[7:0];
        end
    end

    // read data, unmapped codes read zero
    wire [15:0] rd_mux =
        sel_warn  ? 16'(warn_lim_q) :
        sel_fault ? 16'(fault_lim_q) :
        sel_act   ? {8'h00, action_q} : 16'h0000;

    // registered read data
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) rdata_q <= 16'h0000;
        else       rdata_q <= rd_mux;
    end

    // status flags: the set wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            warn_q <= uv_warn;
            if (resp_enter)
                flag_q <= 1'b1;
            else if (clear_req || !cmd_on)
                flag_q <= 1'b0;
        end
    end

    // restart attempt counter
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)          tries_q <= 3'h0;
        else if (go_retry)  tries_q <= 3'h0;
        else if (state_q == uvr_pkg::ST_SHUT && dly.done && !forever_r)
            tries_q <= tries_q + 3'h1;
    end

    // response state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            uvr_pkg::ST_OFF:
                if (cmd_on) state_d = uvr_pkg::ST_RUN;
            uvr_pkg::ST_RUN:
                if (uv_fault) begin
                    case (resp)
                        uvr_pkg::RESP_IGNORE:   state_d = uvr_pkg::ST_RUN;
                        uvr_pkg::RESP_DELAY:    state_d = uvr_pkg::ST_DELAY;
                        uvr_pkg::RESP_SHUTDOWN: state_d = uvr_pkg::ST_SHUT;
                        default:                state_d = uvr_pkg::ST_HOLD;
                    endcase
                end
            uvr_pkg::ST_DELAY:
                if (dly.done) state_d = uv_fault ? uvr_pkg::ST_SHUT : uvr_pkg::ST_RUN;
            uvr_pkg::ST_SHUT:
                if (dly.done) state_d = uvr_pkg::ST_TRY;
            uvr_pkg::ST_TRY:
                if (dly.done) state_d = uv_fault ? uvr_pkg::ST_SHUT : uvr_pkg::ST_RUN;
            uvr_pkg::ST_LATCH:
                if (clear_req) state_d = uvr_pkg::ST_RUN;
            uvr_pkg::ST_HOLD:
                if (!uv_fault) state_d = uvr_pkg::ST_RUN;
            default:
                state_d = uvr_pkg::ST_OFF;
        endcase
        // no retries allowed, or all used up: stay off until cleared
        if ((go_retry && retries == uvr_pkg::RETRY_NONE) || (try_fail && !tries_left))
            state_d = uvr_pkg::ST_LATCH;
        if (other_fault_off_i && state_q != uvr_pkg::ST_OFF)
            state_d = uvr_pkg::ST_LATCH;
        if (!cmd_on)
            state_d = uvr_pkg::ST_OFF;
    end

    // state register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) state_q <= uvr_pkg::ST_OFF;
        else       state_q <= state_d;
    end

    // states in which the delay timer runs
    function automatic logic timed_state(input uvr_pkg::uvr_state_e st);
        return (st == uvr_pkg::ST_DELAY) || (st == uvr_pkg::ST_SHUT)
            || (st == uvr_pkg::ST_TRY);
    endfunction : timed_state

    // one timer for run-on time and retry spacing
    assign dly.code  = dly_code;
    assign dly.unit  = delay_unit_cycles_i;
    assign dly.start = timed_state(state_d) && (state_d != state_q);
    assign dly.abort = !timed_state(state_d);

    uvr_delay_timer u_timer (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .dly       (dly)
    );

    // outputs
    assign output_en_o  = (state_q == uvr_pkg::ST_RUN) || (state_q == uvr_pkg::ST_DELAY)
                        || (state_q == uvr_pkg::ST_TRY);
    assign uv_warning_o = warn_q;
    assign uv_fault_o   = flag_q;
    assign reg_rdata_o  = rdata_q;
endmodule : uvr_supervisor
`default_nettype wire

//--- pkg/uvr_dly_if.sv
// carrier between the supervisor and its delay timer
`timescale 1ns/1ps
`default_nettype none
interface uvr_dly_if;
    logic        start;   // load and run the timer
    logic        abort;   // stop the timer
    logic [2:0]  code;    // power-of-two unit count
    logic [15:0] unit;    // clock cycles in one delay unit
    logic        done;    // one-cycle pulse at expiry
    modport ctrl (output start, abort, code, unit, input done);
    modport timer (input start, abort, code, unit, output done);
endinterface : uvr_dly_if
`default_nettype wire

//--- pkg/uvr_pkg.sv
// shared constants and types of the output undervoltage supervisor
package uvr_pkg;
    // command codes of the three registers
    localparam logic [7:0]  OFS_WARN_LIMIT  = 8'h43;
    localparam logic [7:0]  OFS_FAULT_LIMIT = 8'h44;
    localparam logic [7:0]  OFS_ACTION      = 8'h45;
    // field positions inside the action register
    localparam int          ACT_RESP_LSB    = 6;
    localparam int          ACT_RETRY_LSB   = 3;
    localparam int          ACT_DELAY_LSB   = 0;
    // reset values
    localparam logic [15:0] RST_WARN_LIMIT  = 16'h0000;
    localparam logic [15:0] RST_FAULT_LIMIT = 16'h0000;
    localparam logic [7:0]  RST_ACTION      = 8'h00;
    // response codes
    localparam logic [1:0]  RESP_IGNORE     = 2'h0;
    localparam logic [1:0]  RESP_DELAY      = 2'h1;
    localparam logic [1:0]  RESP_SHUTDOWN   = 2'h2;
    localparam logic [1:0]  RESP_HOLD       = 2'h3;
    // retry codes
    localparam logic [2:0]  RETRY_NONE      = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER   = 3'h7;
    // supervisor states, one-hot
    typedef enum logic [6:0] {
        ST_OFF   = 7'h01,
        ST_RUN   = 7'h02,
        ST_DELAY = 7'h04,
        ST_SHUT  = 7'h08,
        ST_TRY   = 7'h10,
        ST_LATCH = 7'h20,
        ST_HOLD  = 7'h40
    } uvr_state_e;
endpackage : uvr_pkg

//--- tb/uvr_host_model.sv
// host model driving the supervisor's command side
`timescale 1ns/1ps
`default_nettype none
module uvr_host_model (
    // clock
    input  wire logic        ref_clk_i,
    // register port
    output var  logic [7:0]  reg_cmd_o,
    output var  logic        reg_wr_o,
    output var  logic [15:0] reg_wdata_o,
    input  wire logic [15:0] reg_rdata_i,
    // clear and on/off commands
    output var  logic        fault_bit_clr_o,
    output var  logic        clear_faults_o,
    output var  logic        operation_on_o,
    output var  logic        ctrl_pin_o
);
    // idle: output commanded on, unmapped command
    initial begin
        reg_cmd_o = 8'hFF;
        reg_wr_o = 1'b0;
        reg_wdata_o = 16'h0000;
        fault_bit_clr_o = 1'b0;
        clear_faults_o = 1'b0;
        operation_on_o = 1'b1;
        ctrl_pin_o = 1'b1;
    end
    // one-cycle write strobe, stale data inverted
    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge ref_clk_i);
        reg_cmd_o = cmd;
        reg_wr_o = 1'b1;
        reg_wdata_o = data;
        @(negedge ref_clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~data;
    endtask : wr
    // select, then take the registered answer
    task automatic rd(input logic [7:0] cmd, output logic [15:0] data);
        @(negedge ref_clk_i);
        reg_cmd_o = cmd;
        repeat (2) @(negedge ref_clk_i);
        data = reg_rdata_i;
    endtask : rd
    // one clear pulse, single bit or clear-all
    task automatic pulse(input logic bit_only);
        @(negedge ref_clk_i);
        fault_bit_clr_o = bit_only;
        clear_faults_o = !bit_only;
        @(negedge ref_clk_i);
        fault_bit_clr_o = 1'b0;
        clear_faults_o = 1'b0;
    endtask : pulse
    // off then on through the pin or the operation command
    task automatic cycle(input logic by_pin);
        @(negedge ref_clk_i);
        ctrl_pin_o = !by_pin;
        operation_on_o = by_pin;
        repeat (4) @(negedge ref_clk_i);
        ctrl_pin_o = 1'b1;
        operation_on_o = 1'b1;
        repeat (6) @(negedge ref_clk_i);
    endtask : cycle
endmodule : uvr_host_model
`default_nettype wire

//--- tb/uvr_supervisor_checker.sv
// port assertions of the undervoltage supervisor
`timescale 1ns/1ps
`default_nettype none
module uvr_supervisor_checker (
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // register port
    input wire logic [7:0]  reg_cmd_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic [15:0] reg_rdata_o,
    // supervision
    input wire logic [15:0] vout_i,
    input wire logic        fault_bit_clr_i,
    input wire logic        clear_faults_i,
    input wire logic        operation_on_i,
    input wire logic        other_fault_off_i,
    input wire logic        output_en_o,
    input wire logic        uv_warning_o,
    input wire logic        uv_fault_o
);
    logic [15:0] warn_q;
    logic [15:0] flt_q;
    logic [1:0]  resp_q;
    // fault level, output running, output running with flag clear
    wire logic low_w = vout_i < flt_q;
    wire logic on_w  = output_en_o && operation_on_i && !other_fault_off_i;
    wire logic run_w = on_w && !uv_fault_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // shadow of the written limits and response field
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_q <= 16'h0000;
            flt_q  <= 16'h0000;
            resp_q <= 2'h0;
        end else if (reg_wr_i) begin
            if (reg_cmd_i == 8'h43) warn_q <= reg_wdata_i;
            if (reg_cmd_i == 8'h44) flt_q <= reg_wdata_i;
            if (reg_cmd_i == 8'h45) resp_q <= reg_wdata_i[7:6];
        end
    end
    property p_rd_fault; reg_cmd_i == 8'h44 |=> reg_rdata_o == $past(flt_q); endproperty
    a_rd_fault: assert property (p_rd_fault) else $error("fault limit readback");
    property p_warn; uv_warning_o == $past(vout_i < warn_q); endproperty
    a_warn: assert property (p_warn) else $error("warning flag");
    property p_flag; run_w && low_w |=> uv_fault_o; endproperty
    a_flag: assert property (p_flag) else $error("fault flag not set");
    property p_ignore; resp_q == 2'h0 && on_w && low_w |=> output_en_o; endproperty
    a_ignore: assert property (p_ignore) else $error("ignore dropped output");
    property p_shut; resp_q == 2'h2 && run_w && low_w |=> !output_en_o [*2]; endproperty
    a_shut: assert property (p_shut) else $error("shutdown not immediate");
    property p_hold; resp_q == 2'h3 && on_w && low_w |=> !output_en_o; endproperty
    a_hold: assert property (p_hold) else $error("hold left output on");
    property p_clear; (clear_faults_i || fault_bit_clr_i) && !low_w |=> !uv_fault_o; endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    property p_other; other_fault_off_i |=> !output_en_o; endproperty
    a_other: assert property (p_other) else $error("other fault kept output");
endmodule : uvr_supervisor_checker
bind uvr_supervisor uvr_supervisor_checker chk (.ref_clk_i, .rst_i, .reg_cmd_i, .reg_wr_i,
    .reg_wdata_i, .reg_rdata_o, .vout_i, .fault_bit_clr_i, .clear_faults_i, .operation_on_i,
    .other_fault_off_i, .output_en_o, .uv_warning_o, .uv_fault_o);
`default_nettype wire

//--- tb/uvr_supervisor_tb_top.sv
// testbench of the undervoltage supervisor
`timescale 1ns/1ps
`default_nettype none
module uvr_supervisor_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] vout = 16'h8000;
    logic [15:0] unit = 16'h0001;
    logic        other = 1'b0;
    logic [15:0] d, rdata, wdata;
    logic [7:0]  cmd;
    logic        wr, fbc, cf, on, pin, en, warn, flt, en_prev;
    logic [7:0]  cmds [4] = '{8'h43, 8'h44, 8'h45, 8'h46};
    logic [15:0] vals [4] = '{16'h6000, 16'h5000, 16'h00A5, 16'h1234};
    logic [15:0] exps [4] = '{16'h6000, 16'h5000, 16'h00A5, 16'h0000};
    int          mismatches = 0, n_compared = 0, cycles = 0, rises = 0, t_rise = 0, gap = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    uvr_supervisor DUT (.ref_clk_i, .rst_i, .reg_cmd_i(cmd), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .vout_i(vout), .delay_unit_cycles_i(unit), .fault_bit_clr_i(fbc),
        .clear_faults_i(cf), .operation_on_i(on), .ctrl_pin_i(pin), .other_fault_off_i(other),
        .output_en_o(en), .uv_warning_o(warn), .uv_fault_o(flt));
    uvr_host_model host (.ref_clk_i, .reg_cmd_o(cmd), .reg_wr_o(wr), .reg_wdata_o(wdata),
        .reg_rdata_i(rdata), .fault_bit_clr_o(fbc), .clear_faults_o(cf), .operation_on_o(on),
        .ctrl_pin_o(pin));
    // restart edges, their spacing, hang guard; enable read where it has settled
    always @(negedge ref_clk_i) begin
        cycles = cycles + 1;
        if (en === 1'b1 && en_prev === 1'b0) begin
            rises = rises + 1;
            gap = cycles - t_rise;
            t_rise = cycles;
        end
        en_prev = en;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end
    function automatic logic [15:0] st();
        return {13'h0000, warn, flt, en};
    endfunction : st
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wait_n
    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // register access, warning, then each response and retry code
    initial begin
        wait_n(8);
        rst_i = 1'b0;
        wait_n(4);
        for (int i = 0; i < 4; i++) begin
            host.rd(cmds[i], d);
            cmp("reset_value", 16'h0000, d);
            host.wr(cmds[i], vals[i]);
            host.rd(cmds[i], d);
            cmp("readback", exps[i], d);
        end
        vout = 16'h5FFF;
        wait_n(3);
        cmp("warn_only", 16'h0005, st());
        vout = 16'h6000;
        wait_n(3);
        cmp("warn_edge", 16'h0001, st());
        host.wr(8'h45, 16'h0000);
        vout = 16'h4000;
        wait_n(20);
        cmp("ignore", 16'h0007, st());
        other = 1'b1;
        wait_n(3);
        cmp("other_off", 16'h0006, st());
        other = 1'b0;
        vout = 16'h8000;
        host.pulse(1'b0);
        wait_n(3);
        cmp("clear_all", 16'h0001, st());
        host.wr(8'h45, 16'h00C0);
        vout = 16'h4000;
        wait_n(5);
        cmp("hold_off", 16'h0006, st());
        vout = 16'h8000;
        wait_n(4);
        cmp("hold_resume", 16'h0003, st());
        host.pulse(1'b1);
        wait_n(2);
        cmp("bit_clear", 16'h0001, st());
        unit = 16'h0004;
        host.wr(8'h45, 16'h0042);
        vout = 16'h4000;
        wait_n(10);
        cmp("run_on", 16'h0007, st());
        wait_n(12);
        cmp("delay_end", 16'h0006, st());
        vout = 16'h8000;
        wait_n(100);
        cmp("no_retry", 16'h0002, st());
        host.cycle(1'b0);
        cmp("op_cycle", 16'h0001, st());
        unit = 16'h0001;
        for (int n = 1; n < 8; n++) begin
            host.wr(8'h45, {8'h00, 2'h2, 3'(n), 3'h0});
            rises = 0;
            vout = 16'h4000;
            wait_n(300);
            cmp("retries", (n == 7) ? 16'h0001 : 16'(n), 16'((n == 7) ? (rises > 20) : rises));
            if (n < 7) cmp("latched", 16'h0006, st());
            vout = 16'h8000;
            host.cycle(1'b1);
            cmp("pin_cycle", 16'h0001, st());
        end
        unit = 16'h0002;
        host.wr(8'h45, 16'h00BB);
        vout = 16'h4000;
        wait_n(200);
        cmp("spacing", 16'h0001, 16'(gap >= 32 && gap <= 36));
        vout = 16'h8000;
        host.cycle(1'b0);
        summarize();
    end
endmodule : uvr_supervisor_tb_top
`default_nettype wire
